// [design/uacp_top.sv]
// Ancillary pin control: bus style, reset pin, isolation, charge pump, rx source, rate and clock buffer
//
// Contract
// - Style pin high selects separate read/write strobes; low selects direction line.
// - Reset pin is active high in strobe style, active low in direction style.
// - Reset held at least 40 ns returns registers and UART outputs to defaults.
// - During reset, transmitter output stays high and receiver input is ignored.
// - Isolation pin during sleep keeps host bus activity away from the core.
// - Autosleep pin high with oscillator stopped turns the charge pump off.
// - Channel B receive comes from logic-level pin when select high, else line-level.
// - Rate pin high allows 1 Mbps maximum, low limits to 250 Kbps.
// - A buffered copy of the oscillator input drives the oscillator output pin; the pin is held low while the oscillator is stopped.
// - Host bus cycles are timed by chip select and strobes, not the oscillator.
`include "uacp_defines.svh"

module uacp_top #(
    parameter int RST_CNT_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic bus_style_sel_i,
    input wire logic dev_reset_pin_i,
    input wire logic bus_isolate_request_i,
    input wire logic pump_autosleep_i,
    input wire logic rx_source_select_i,
    input wire logic logic_level_rx_in_i,
    input wire logic line_level_rx_in_i,
    input wire logic rate_select_i,
    input wire logic host_cs_b_i,
    input wire logic host_rd_b_i,
    input wire logic host_wr_b_i,
    input wire logic host_rw_i,
    input wire logic osc_input_i,
    input wire logic core_tx_i,
    output logic uart_tx_o,
    output logic core_rx_o,
    output logic core_read_o,
    output logic core_write_o,
    output logic core_reset_o,
    output logic bus_isolated_o,
    output logic pump_enable_o,
    output logic rate_fast_o,
    output logic osc_buffered_out_o
);
    localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(`UACP_RST_MIN_CYC - 1);

    logic [`UACP_PIN_W-1:0] pins, s1_q, s2_q, s3_q, filt_q, filt_d;
    uacp_pkg::uacp_rst_state_t st_q, st_d;
    logic [RST_CNT_W-1:0] cnt_q, cnt_d;
    logic [31:0] ctrl_q, ctrl_d, rdata_d, stat;
    logic pready_d, slverr_d, rd_act, wr_act, rd_act_q, wr_act_q, blocked, rst_act, osc_stop;
    logic tx_d, rx_d, crd_d, cwr_d, iso_d, pump_d, osc_d;

    assign pins = {osc_input_i, host_rw_i, host_wr_b_i, host_rd_b_i, host_cs_b_i, rate_select_i,
                   line_level_rx_in_i, logic_level_rx_in_i, rx_source_select_i, pump_autosleep_i,
                   bus_isolate_request_i, dev_reset_pin_i, bus_style_sel_i};

    // Three stages; a bit changes only once the last two agree
    always_comb begin
        filt_d = filt_q;
        for (int i = 0; i < `UACP_PIN_W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                filt_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        s1_q <= pins;
        s2_q <= s1_q;
        s3_q <= s2_q;
        // Start from the synchronised pins so idle strobes and reset pin give no false edge after reset
        if (!rst_b_i) begin
            filt_q <= s3_q;
        end else begin
            filt_q <= filt_d;
        end
    end

    // Active level follows the bus style
    assign rst_act = filt_q[`UACP_PIN_STYLE] ? filt_q[`UACP_PIN_RESET] : !filt_q[`UACP_PIN_RESET];

    // Short glitches are not taken as a reset
    always_comb begin
        st_d = st_q;
        cnt_d = '0;
        case (st_q)
            uacp_pkg::UACP_RST_IDLE: begin
                if (rst_act) begin
                    st_d = uacp_pkg::UACP_RST_QUAL;
                end
            end
            uacp_pkg::UACP_RST_QUAL: begin
                cnt_d = cnt_q + RST_CNT_W'(1);
                if (!rst_act) begin
                    st_d = uacp_pkg::UACP_RST_IDLE;
                end else if (cnt_q == RST_LAST - RST_CNT_W'(1)) begin
                    st_d = uacp_pkg::UACP_RST_ACTIVE;
                end
            end
            uacp_pkg::UACP_RST_ACTIVE: begin
                if (!rst_act) begin
                    st_d = uacp_pkg::UACP_RST_IDLE;
                end
            end
            default: begin
                st_d = uacp_pkg::UACP_RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q <= uacp_pkg::UACP_RST_IDLE;
            cnt_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Host strobes decoded purely from pins, no oscillator involved
    assign rd_act = !filt_q[`UACP_PIN_CS_B] &&
                    (filt_q[`UACP_PIN_STYLE] ? !filt_q[`UACP_PIN_RD_B] : filt_q[`UACP_PIN_RW]);
    assign wr_act = !filt_q[`UACP_PIN_CS_B] &&
                    (filt_q[`UACP_PIN_STYLE] ? !filt_q[`UACP_PIN_WR_B] : !filt_q[`UACP_PIN_RW]);
    assign osc_stop = ctrl_q[`UACP_CTRL_OSC_STOP];

    always_comb begin
        iso_d = filt_q[`UACP_PIN_ISOLATE] && osc_stop;
        blocked = iso_d || (st_d == uacp_pkg::UACP_RST_ACTIVE);
        crd_d = rd_act && !rd_act_q && !blocked;
        cwr_d = wr_act && !wr_act_q && !blocked;
        pump_d = !(filt_q[`UACP_PIN_AUTOSLEEP] && osc_stop);
        osc_d = filt_q[`UACP_PIN_OSC] && !osc_stop;
        tx_d = core_tx_i;
        rx_d = filt_q[`UACP_PIN_RX_SEL] ? filt_q[`UACP_PIN_RX_LOGIC] : filt_q[`UACP_PIN_RX_LINE];
        if (st_d == uacp_pkg::UACP_RST_ACTIVE) begin
            tx_d = 1'b1;
            rx_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            core_read_o <= 1'b0;
            core_write_o <= 1'b0;
            bus_isolated_o <= 1'b0;
            pump_enable_o <= 1'b1;
            osc_buffered_out_o <= 1'b0;
            uart_tx_o <= 1'b1;
            core_rx_o <= 1'b1;
            core_reset_o <= 1'b0;
            rate_fast_o <= 1'b0;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            core_read_o <= crd_d;
            core_write_o <= cwr_d;
            bus_isolated_o <= iso_d;
            pump_enable_o <= pump_d;
            osc_buffered_out_o <= osc_d;
            uart_tx_o <= tx_d;
            core_rx_o <= rx_d;
            core_reset_o <= (st_d == uacp_pkg::UACP_RST_ACTIVE);
            rate_fast_o <= filt_q[`UACP_PIN_RATE];
        end
    end

    // APB slave, one wait state so every output leaves a flop
    always_comb begin
        stat = '0;
        stat[`UACP_STAT_STYLE] = filt_q[`UACP_PIN_STYLE];
        stat[`UACP_STAT_RATE_FAST] = rate_fast_o;
        stat[`UACP_STAT_RX_SEL] = filt_q[`UACP_PIN_RX_SEL];
        stat[`UACP_STAT_PUMP_EN] = pump_enable_o;
        stat[`UACP_STAT_ISOLATED] = bus_isolated_o;
        stat[`UACP_STAT_DEV_RESET] = core_reset_o;
        stat[`UACP_STAT_OSC_RUN] = !osc_stop;
        pready_d = psel_i && penable_i && !pready_o;
        slverr_d = 1'b0;
        rdata_d = '0;
        ctrl_d = ctrl_q;
        if (pready_d) begin
            case (paddr_i)
                `UACP_CTRL_OFS: rdata_d = ctrl_q;
                `UACP_STAT_OFS: rdata_d = stat;
                default: slverr_d = 1'b1;
            endcase
        end
        if (pready_o && pwrite_i && paddr_i == `UACP_CTRL_OFS) begin
            ctrl_d = 32'h0;
            ctrl_d[`UACP_CTRL_OSC_STOP] = pwdata_i[`UACP_CTRL_OSC_STOP];
        end
        if (st_d == uacp_pkg::UACP_RST_ACTIVE) begin
            ctrl_d = `UACP_CTRL_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ctrl_q <= `UACP_CTRL_RESET;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            pready_o <= pready_d;
            pslverr_o <= slverr_d;
            prdata_o <= rdata_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    logic [7:0] act_run_q;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !rst_act) begin
            act_run_q <= '0;
        end else if (act_run_q != 8'hff) begin
            act_run_q <= act_run_q + 8'h01;
        end
    end

    sequence s_read_start;
        rd_act && !rd_act_q && !blocked;
    endsequence
    sequence s_pump_off_cond;
        filt_q[`UACP_PIN_AUTOSLEEP] && osc_stop;
    endsequence

    a_read_decode: assert property (s_read_start |=> core_read_o) else $error("read strobe lost");
    a_reset_polarity: assert property (core_reset_o |-> $past(filt_q[`UACP_PIN_RESET]) ==
        $past(filt_q[`UACP_PIN_STYLE])) else $error("reset level wrong");
    a_reset_min_width: assert property ($rose(core_reset_o) |-> act_run_q >= 8'(`UACP_RST_MIN_CYC))
        else $error("reset taken too early");
    a_reset_clears_ctrl: assert property (core_reset_o |-> ctrl_q == `UACP_CTRL_RESET)
        else $error("ctrl not cleared");
    a_tx_held_high: assert property (core_reset_o |-> uart_tx_o && core_rx_o)
        else $error("tx or rx active in reset");
    a_isolate_blocks: assert property (bus_isolated_o |-> !core_read_o && !core_write_o)
        else $error("strobe passed isolation");
    a_pump_off: assert property (s_pump_off_cond |=> !pump_enable_o) else $error("pump not off");
    a_pump_back_on: assert property (!filt_q[`UACP_PIN_AUTOSLEEP] |=> pump_enable_o)
        else $error("pump not re-enabled");
    a_rx_select: assert property (!core_reset_o ##0 !(st_d == uacp_pkg::UACP_RST_ACTIVE) && filt_q[`UACP_PIN_RX_SEL]
        |=> core_rx_o == $past(filt_q[`UACP_PIN_RX_LOGIC])) else $error("rx source wrong");
    a_rate_select: assert property (##1 rate_fast_o == $past(filt_q[`UACP_PIN_RATE]))
        else $error("rate flag wrong");
    a_osc_buffer: assert property (!osc_stop |=> osc_buffered_out_o == $past(filt_q[`UACP_PIN_OSC]))
        else $error("osc copy wrong");
    a_strobe_from_pins: assert property (core_write_o |-> $past(wr_act) && !$past(wr_act_q))
        else $error("write without strobe");
endmodule : uacp_top

// [shared/uacp_defines.svh]
// Offsets, field positions and timing counts for the ancillary pin control block
`ifndef UACP_DEFINES_SVH
`define UACP_DEFINES_SVH

`define UACP_CLK_PERIOD_NS 8
`define UACP_RST_MIN_NS 40
// Least time rounds up to whole cycles
`define UACP_RST_MIN_CYC ((`UACP_RST_MIN_NS + `UACP_CLK_PERIOD_NS - 1) / `UACP_CLK_PERIOD_NS)

`define UACP_CTRL_OFS 12'h000
`define UACP_STAT_OFS 12'h004

`define UACP_CTRL_OSC_STOP 0
`define UACP_CTRL_RESET 32'h0000_0000

`define UACP_STAT_STYLE 0
`define UACP_STAT_RATE_FAST 1
`define UACP_STAT_RX_SEL 2
`define UACP_STAT_PUMP_EN 3
`define UACP_STAT_ISOLATED 4
`define UACP_STAT_DEV_RESET 5
`define UACP_STAT_OSC_RUN 6

`define UACP_PIN_W 13
`define UACP_PIN_STYLE 0
`define UACP_PIN_RESET 1
`define UACP_PIN_ISOLATE 2
`define UACP_PIN_AUTOSLEEP 3
`define UACP_PIN_RX_SEL 4
`define UACP_PIN_RX_LOGIC 5
`define UACP_PIN_RX_LINE 6
`define UACP_PIN_RATE 7
`define UACP_PIN_CS_B 8
`define UACP_PIN_RD_B 9
`define UACP_PIN_WR_B 10
`define UACP_PIN_RW 11
`define UACP_PIN_OSC 12

`endif

// [shared/uacp_pkg.sv]
// Types shared by the ancillary pin control block
package uacp_pkg;
    typedef enum logic [2:0] {
        UACP_RST_IDLE = 3'b001,
        UACP_RST_QUAL = 3'b010,
        UACP_RST_ACTIVE = 3'b100
    } uacp_rst_state_t;
endpackage : uacp_pkg

// [tb/uacp_host_model.sv]
// Host processor model driving chip select and strobes
module uacp_host_model #(
    parameter int HOLD = 8
) (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic wr_i,
    input wire logic style_i,
    output logic cs_b_o,
    output logic rd_b_o,
    output logic wr_b_o,
    output logic rw_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial begin
        cs_b_o = 1'b1;
        rd_b_o = 1'b1;
        wr_b_o = 1'b1;
        rw_o = 1'b1;
    end
    always @(posedge clk_i) begin
        if (cnt > 0) begin
            cnt <= cnt - 1;
            // Cycle ends only when strobes let go; released direction line does not keep its value
            if (cnt == 1) begin
                cs_b_o <= 1'b1;
                rd_b_o <= 1'b1;
                wr_b_o <= 1'b1;
                rw_o <= ~rw_o;
            end
        end else if (go_i) begin
            cnt <= HOLD;
            cs_b_o <= 1'b0;
            rd_b_o <= wr_i | !style_i;
            wr_b_o <= !wr_i | !style_i;
            rw_o <= !wr_i;
        end
    end
endmodule : uacp_host_model

// [tb/uart_ancillary_pin_control_bench.sv]
// Self-checking bench for the ancillary pin control block
module uart_ancillary_pin_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r = 32'h0000_c7ba;
    logic style = 1'b1, rpin = 1'b0, iso = 1'b0, asl = 1'b0, rxsel = 1'b0, rxl = 1'b0, rxn = 1'b0;
    logic rate = 1'b0, osc = 1'b0, ctx = 1'b0, go = 1'b0, gowr = 1'b0, cs_b, rd_b, wr_b, rw;
    logic tx, rx, crd, cwr, crst, isod, pump, fast, osco;
    logic [32:0] expq[$];
    logic [32:0] e;
    int error_cnt = 0, tests_run = 0, rd_cnt = 0, wr_cnt = 0;

    always #4 clk = ~clk;

    uacp_top #(.RST_CNT_W(4)) dut (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .bus_style_sel_i(style), .dev_reset_pin_i(rpin), .bus_isolate_request_i(iso),
        .pump_autosleep_i(asl), .rx_source_select_i(rxsel), .logic_level_rx_in_i(rxl),
        .line_level_rx_in_i(rxn), .rate_select_i(rate), .host_cs_b_i(cs_b), .host_rd_b_i(rd_b),
        .host_wr_b_i(wr_b), .host_rw_i(rw), .osc_input_i(osc), .core_tx_i(ctx), .uart_tx_o(tx),
        .core_rx_o(rx), .core_read_o(crd), .core_write_o(cwr), .core_reset_o(crst),
        .bus_isolated_o(isod), .pump_enable_o(pump), .rate_fast_o(fast), .osc_buffered_out_o(osco));

    uacp_host_model #(.HOLD(8)) host_m (.clk_i(clk), .go_i(go), .wr_i(gowr), .style_i(style),
        .cs_b_o(cs_b), .rd_b_o(rd_b), .wr_b_o(wr_b), .rw_o(rw));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk(input logic g, input logic x);
        tests_run++;
        if (g !== x) begin
            error_cnt++;
            $display("[ERR] %0t pin got %b exp %b", $time, g, x);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        if (!w) expq.push_back(x);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic host(input logic w);
        go <= 1'b1;
        gowr <= w;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
    endtask : host

    task automatic settle;
        repeat (8) @(posedge clk);
    endtask : settle

    task automatic wrap_up;
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // Expected read results are queued by the driver and matched here
    always @(posedge clk) begin
        if (crd === 1'b1) rd_cnt++;
        if (cwr === 1'b1) wr_cnt++;
        if (pready === 1'b1 && pwrite === 1'b0) begin
            e = expq.pop_front();
            tests_run++;
            if ({pslverr, prdata} !== e) begin
                error_cnt++;
                $display("[ERR] %0t read got %h exp %h", $time, {pslverr, prdata}, e);
            end
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        settle();
        chk(pump, 1'b1);
        for (int i = 0; i < 8; i++) begin
            r = lfsr(r);
            rxsel <= r[0];
            rxl <= r[1];
            rxn <= r[2];
            rate <= r[3];
            osc <= r[4];
            settle();
            chk(rx, r[0] ? r[1] : r[2]);
            chk(fast, r[3]);
            chk(osco, r[4]);
            apb(1'b0, 12'h004, 32'h0, {1'b0, 25'h0, 1'b1, 2'b00, 1'b1, r[0], r[3], 1'b1});
        end
        apb(1'b0, 12'h008, 32'h0, {1'b1, 32'h0});
        host(1'b0);
        host(1'b1);
        chk(rd_cnt == 1 && wr_cnt == 1, 1'b1);
        apb(1'b1, 12'h000, 32'h1, 33'h0);
        asl <= 1'b1;
        settle();
        chk(pump, 1'b0);
        chk(osco, 1'b0);
        iso <= 1'b1;
        settle();
        chk(isod, 1'b1);
        host(1'b0);
        chk(rd_cnt == 1, 1'b1);
        iso <= 1'b0;
        asl <= 1'b0;
        settle();
        chk(pump, 1'b1);
        asl <= 1'b1;
        settle();
        chk(pump, 1'b0);
        apb(1'b1, 12'h000, 32'h0, 33'h0);
        settle();
        chk(pump, 1'b1);
        apb(1'b1, 12'h000, 32'h1, 33'h0);
        rxl <= 1'b0;
        rxn <= 1'b0;
        chk(tx, 1'b0);
        // 16 ns is below the least reset width and must be ignored
        rpin <= 1'b1;
        repeat (2) @(posedge clk);
        rpin <= 1'b0;
        repeat (12) begin
            @(posedge clk);
            chk(crst, 1'b0);
        end
        rpin <= 1'b1;
        repeat (14) @(posedge clk);
        chk(crst, 1'b1);
        chk(tx, 1'b1);
        chk(rx, 1'b1);
        rpin <= 1'b0;
        settle();
        chk(crst, 1'b0);
        apb(1'b0, 12'h000, 32'h0, 33'h0);
        rpin <= 1'b1;
        style <= 1'b0;
        settle();
        chk(crst, 1'b0);
        rpin <= 1'b0;
        repeat (14) @(posedge clk);
        chk(crst, 1'b1);
        rpin <= 1'b1;
        settle();
        host(1'b0);
        host(1'b1);
        chk(rd_cnt == 2 && wr_cnt == 2, 1'b1);
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule : uart_ancillary_pin_control_bench
